// ===== common/hub_cfg_pkg.sv
// Package for the hub feature and serial-configuration register pair.
// Assumes an 8-bit register port driven by the configuration front end.
package hub_cfg_pkg;

    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [7:0] FEATURE_CFG_ADDR = 8'hF0;
    localparam logic [7:0] SERIAL_STS_ADDR  = 8'hF8;
    localparam logic [7:0] FEATURE_CFG_RST  = 8'h00;
    localparam logic [7:0] SERIAL_STS_RST   = 8'h00;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int SSC_OFF_BIT     = 0;
    localparam int DELAY_LSB       = 1;
    localparam int DELAY_MSB       = 3;
    localparam int STATUS_EN_BIT   = 4;
    localparam int CFG_ACTIVE_BIT  = 0;
    localparam int IFACE_RESET_BIT = 1;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLOCK_HZ       = 25_000_000;
    localparam int DELAY_STEP_MS  = 200;
    localparam int DELAY_STEP_CYC = CLOCK_HZ / 1000 * DELAY_STEP_MS;

    typedef enum logic [1:0] {
        CFG_MODE_NONE  = 2'h0,
        CFG_MODE_I2C   = 2'h1,
        CFG_MODE_SMBUS = 2'h3
    } cfg_mode_e;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage : hub_cfg_pkg

// ===== rtl/power_reenable_timer.sv
// Hold-off timer for re-enabling downstream port power.
// Assumes one clock domain; start is a one-cycle pulse.
`timescale 1ns/100ps
module power_reenable_timer
    import hub_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = DELAY_STEP_CYC
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic [2:0] steps,
    output logic            busy
);
    initial begin
        if (STEP_CYCLES < 1) $error("STEP_CYCLES must be at least 1");
    end

    logic [31:0] cycleCnt_q, cycleCnt_d;
    logic [2:0]  stepCnt_q, stepCnt_d;
    logic        busy_q, busy_d;

    // -------------------------------------------------------------------
    // Step counting: steps x STEP_CYCLES
    // -------------------------------------------------------------------
    always_comb begin
        cycleCnt_d = cycleCnt_q;
        stepCnt_d  = stepCnt_q;
        busy_d     = busy_q;
        if (start) begin
            stepCnt_d  = steps;
            cycleCnt_d = 32'h0;
            busy_d     = (steps != 3'h0);
        end else if (busy_q) begin
            if (cycleCnt_q == 32'(STEP_CYCLES - 1)) begin
                cycleCnt_d = 32'h0;
                stepCnt_d  = stepCnt_q - 3'h1;
                busy_d     = (stepCnt_q != 3'h1);
            end else begin
                cycleCnt_d = cycleCnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cycleCnt_q <= 32'h0;
            stepCnt_q  <= 3'h0;
            busy_q     <= 1'b0;
        end else begin
            cycleCnt_q <= cycleCnt_d;
            stepCnt_q  <= stepCnt_d;
            busy_q     <= busy_d;
        end
    end

    assign busy = busy_q;

endmodule : power_reenable_timer

// ===== rtl/hub_feature_and_smbus_cfg_regs.sv
// Feature configuration and serial-configuration status registers.
// Assumes a byte register port from the EEPROM loader or serial slave.
`timescale 1ns/100ps
// Functional notes
// R1 - Delay field bits 3:1 sets the power re-enable wait of value x 200 ms.
// R2 - Feature bit 0 set turns the PLL spread spectrum off.
// R3 - Feature fields take the EEPROM load and later host overwrites.
// R4 - The delay field is writable by loader or host; the last value is used.
// R5 - Status bits 7:2 always read zero.
// R6 - Setting the interface reset bit restores all registers to reset values.
// R7 - The interface reset bit is settable only in SMBus mode.
// R8 - The interface reset also sets the configuration-active flag.
// R9 - After an interface reset the host rewrites needed registers.
// R10 - Interface reset sets on written one and self-clears when done.
// R11 - Entering I2C or SMBus mode sets the configuration-active flag.
// R12 - The upstream port may not connect while the flag is one.
// R13 - In I2C mode the flag clears when I2C mode is left.
// R14 - In SMBus mode the host clears the flag to end configuration.
// R15 - Writing one clears the flag; writing zero leaves it.
// R16 - Feature bit 4 gates the four hub status outputs.
// R17 - Software keeps feature bits 7:5 at zero.
module hub_feature_and_smbus_cfg_regs
    import hub_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = DELAY_STEP_CYC
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire reg_req_s   regReq,
    input  wire cfg_mode_e  cfgMode,
    input  wire logic       powerRemoveReq,
    input  wire logic       portPowerWanted,
    input  wire logic [3:0] hubStatusIn,
    output logic [7:0]      regRdata,
    output logic            pllSscOff,
    output logic            portPowerEnableOut,
    output logic            upstreamConnectAllow,
    output logic            highspeedUpStatus,
    output logic            highspeedSuspendStatus,
    output logic            superspeedUpStatus,
    output logic            superspeedSuspendStatus
);
    logic [7:0] featureCfg_q, featureCfg_d;
    logic       cfgInProgress_q, cfgInProgress_d;
    logic       ifaceReset_q, ifaceReset_d;
    cfg_mode_e  mode_q;
    logic [7:0] rdata_q, rdata_d;
    logic       pwrOut_q, pwrOut_d;
    logic       connect_q, connect_d;
    logic [3:0] status_q, status_d;
    logic       sscOff_q;
    logic       wrFeature, wrStatus, delayBusy, enteredMode, leftI2c;

    // Refuse a step length the hold-off timer cannot count
    initial begin
        if (STEP_CYCLES < 1) $error("STEP_CYCLES must be at least 1");
    end

    assign wrFeature = regReq.write && regReq.addr == FEATURE_CFG_ADDR;
    assign wrStatus  = regReq.write && regReq.addr == SERIAL_STS_ADDR;
    assign enteredMode = (cfgMode != CFG_MODE_NONE) && (cfgMode != mode_q);
    assign leftI2c = (mode_q == CFG_MODE_I2C) && (cfgMode != CFG_MODE_I2C);

    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    always_comb begin
        featureCfg_d    = featureCfg_q;
        cfgInProgress_d = cfgInProgress_q;
        ifaceReset_d    = 1'b0; // R10
        if (ifaceReset_q) begin
            featureCfg_d    = FEATURE_CFG_RST; // R6
            cfgInProgress_d = 1'b1; // R8
        end else begin
            if (wrFeature) begin
                featureCfg_d = regReq.wdata; // R3 R4
            end
            if (wrStatus && regReq.wdata[CFG_ACTIVE_BIT]) begin
                cfgInProgress_d = 1'b0; // R15
            end
            if (leftI2c) begin
                cfgInProgress_d = 1'b0; // R13
            end
            if (enteredMode) begin
                cfgInProgress_d = 1'b1; // R11
            end
            if (wrStatus && regReq.wdata[IFACE_RESET_BIT]
                && mode_q == CFG_MODE_SMBUS) begin
                ifaceReset_d = 1'b1; // R7 R10
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            featureCfg_q    <= FEATURE_CFG_RST;
            cfgInProgress_q <= SERIAL_STS_RST[CFG_ACTIVE_BIT];
            ifaceReset_q    <= SERIAL_STS_RST[IFACE_RESET_BIT];
            mode_q          <= CFG_MODE_NONE;
        end else begin
            featureCfg_q    <= featureCfg_d;
            cfgInProgress_q <= cfgInProgress_d;
            ifaceReset_q    <= ifaceReset_d;
            mode_q          <= cfgMode;
        end
    end

    // -------------------------------------------------------------------
    // Power re-enable delay
    // -------------------------------------------------------------------
    power_reenable_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_timer (
        .clock (clock),
        .srst  (srst),
        .start (powerRemoveReq),
        .steps (featureCfg_q[DELAY_MSB:DELAY_LSB]), // R1 R4
        .busy  (delayBusy)
    );

    // -------------------------------------------------------------------
    // Outputs and read data
    // -------------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (regReq.read) begin
            unique case (regReq.addr)
                FEATURE_CFG_ADDR: rdata_d = featureCfg_q;
                SERIAL_STS_ADDR:  rdata_d = {6'h00, ifaceReset_q,
                                             cfgInProgress_q}; // R5
                default:          rdata_d = 8'h00;
            endcase
        end
        pwrOut_d  = portPowerWanted && !delayBusy && !powerRemoveReq; // R1
        connect_d = !cfgInProgress_d; // R12
        status_d  = featureCfg_d[STATUS_EN_BIT] ? hubStatusIn : 4'h0; // R16
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q   <= 8'h00;
            pwrOut_q  <= 1'b0;
            connect_q <= 1'b0;
            status_q  <= 4'h0;
            sscOff_q  <= 1'b0;
        end else begin
            rdata_q   <= rdata_d;
            pwrOut_q  <= pwrOut_d;
            connect_q <= connect_d;
            status_q  <= status_d;
            sscOff_q  <= featureCfg_d[SSC_OFF_BIT]; // R2
        end
    end

    assign regRdata                = rdata_q;
    assign pllSscOff               = sscOff_q;
    assign portPowerEnableOut      = pwrOut_q;
    assign upstreamConnectAllow    = connect_q;
    assign highspeedUpStatus       = status_q[0];
    assign highspeedSuspendStatus  = status_q[1];
    assign superspeedUpStatus      = status_q[2];
    assign superspeedSuspendStatus = status_q[3];

endmodule : hub_feature_and_smbus_cfg_regs

// ===== tb/hub_cfg_sva.sv
// Checker for the feature and status register pair.
// Assumes binding to the register block top.
`timescale 1ns/100ps
module hub_cfg_sva
    import hub_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = 10
) (
    input wire logic       clock,
    input wire logic       srst,
    input wire reg_req_s   regReq,
    input wire cfg_mode_e  cfgMode,
    input wire logic       powerRemoveReq,
    input wire logic       portPowerWanted,
    input wire logic [7:0] regRdata,
    input wire logic       pllSscOff,
    input wire logic       portPowerEnableOut,
    input wire logic       upstreamConnectAllow,
    input wire logic       highspeedUpStatus
);
    localparam int HI = STEP_CYCLES + 3;
    logic [2:0] delay_q;
    logic [2:0] delay_d;
    wire wF0 = regReq.write && regReq.addr == FEATURE_CFG_ADDR;
    wire wF8 = regReq.write && regReq.addr == SERIAL_STS_ADDR;
    wire rstW = wF8 && regReq.wdata[1] && cfgMode == CFG_MODE_SMBUS;
    // Shadow of the delay field
    always_comb delay_d = (srst || rstW) ? 3'h0 :
                          wF0 ? regReq.wdata[3:1] : delay_q;
    always_ff @(posedge clock) delay_q <= delay_d;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    AST_SSC: assert property (wF0 |=> pllSscOff == $past(regReq.wdata[0]))
        else $error("ssc");
    AST_RSVD: assert property (regReq.read && regReq.addr == SERIAL_STS_ADDR
        |=> regRdata[7:2] == 6'h00) else $error("rsvd");
    AST_IRST: assert property (rstW |-> ##[2:3] !pllSscOff
        && !upstreamConnectAllow) else $error("iface reset");
    AST_IGN: assert property (wF8 && regReq.wdata == 8'h02 && pllSscOff
        && cfgMode == CFG_MODE_I2C |=> pllSscOff[*3]) else $error("ign");
    AST_ENTER: assert property (cfgMode != CFG_MODE_NONE
        && $changed(cfgMode)
        |-> ##[1:2] !upstreamConnectAllow) else $error("enter");
    AST_LEAVE: assert property ($past(cfgMode) == CFG_MODE_I2C
        && cfgMode == CFG_MODE_NONE |-> ##[1:3] upstreamConnectAllow)
        else $error("leave");
    AST_CLR: assert property (wF8 && regReq.wdata == 8'h01
        && $stable(cfgMode)
        |-> ##[1:3] upstreamConnectAllow) else $error("clear");
    AST_STS: assert property (wF0 && !regReq.wdata[4]
        |-> ##2 !highspeedUpStatus) else $error("sts");
    AST_HOLD: assert property (powerRemoveReq && delay_q != 3'h0
        |=> !portPowerEnableOut[*8]) else $error("hold");
    AST_REEN: assert property (powerRemoveReq && delay_q == 3'h1
        && portPowerWanted |-> ##[STEP_CYCLES:HI] portPowerEnableOut)
        else $error("reenable");
endmodule : hub_cfg_sva
bind hub_feature_and_smbus_cfg_regs hub_cfg_sva #(
    .STEP_CYCLES(STEP_CYCLES)) hub_cfg_sva_i (.clock(clock), .srst(srst),
    .regReq(regReq), .cfgMode(cfgMode), .powerRemoveReq(powerRemoveReq),
    .portPowerWanted(portPowerWanted), .regRdata(regRdata),
    .pllSscOff(pllSscOff), .portPowerEnableOut(portPowerEnableOut),
    .upstreamConnectAllow(upstreamConnectAllow),
    .highspeedUpStatus(highspeedUpStatus));

// ===== tb/cfg_host_model.sv
// Serial configuration host issuing single byte accesses.
// Assumes read data valid one cycle after the read edge.
`timescale 1ns/100ps
module cfg_host_model
    import hub_cfg_pkg::*;
(
    input  wire logic       clock,
    input  wire logic [7:0] rdata,
    output reg_req_s        req
);
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock) req = '{1'b1, 1'b0, a, d};
        @(negedge clock) req = '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge clock) req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clock) req = '{1'b0, 1'b0, ~a, 8'hFF};
        q = rdata;
    endtask : rd
endmodule : cfg_host_model

// ===== tb/hub_feature_and_smbus_cfg_regs_bench.sv
// Bench for the feature and status register pair.
// Assumes the host model owns the register port.
`timescale 1ns/100ps
module hub_feature_and_smbus_cfg_regs_bench;
    import hub_cfg_pkg::*;
    localparam int STEP = 10;
    logic clock, srst, powerRemoveReq, portPowerWanted, pllSscOff;
    logic portPowerEnableOut, upstreamConnectAllow;
    cfg_mode_e cfgMode;
    reg_req_s regReq;
    logic [3:0] hubStatusIn;
    wire [3:0] sts;
    logic [7:0] regRdata, q;
    int badCount, compares, n;
    cfg_host_model cfg_host_model_i (.clock(clock), .rdata(regRdata),
        .req(regReq));
    hub_feature_and_smbus_cfg_regs #(.STEP_CYCLES(STEP))
    hub_feature_and_smbus_cfg_regs_i (.clock(clock), .srst(srst),
        .regReq(regReq), .cfgMode(cfgMode), .powerRemoveReq(powerRemoveReq),
        .portPowerWanted(portPowerWanted), .hubStatusIn(hubStatusIn),
        .regRdata(regRdata), .pllSscOff(pllSscOff),
        .portPowerEnableOut(portPowerEnableOut),
        .upstreamConnectAllow(upstreamConnectAllow),
        .highspeedUpStatus(sts[0]), .highspeedSuspendStatus(sts[1]),
        .superspeedUpStatus(sts[2]), .superspeedSuspendStatus(sts[3]));
    task automatic chk(input string nm, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            badCount++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rdChk(input logic [7:0] a, e, input string nm);
        cfg_host_model_i.rd(a, q);
        chk(nm, e, q);
    endtask : rdChk
    task automatic setMode(input cfg_mode_e m);
        @(negedge clock) cfgMode = m;
        repeat (3) @(negedge clock);
    endtask : setMode
    task automatic endSim;
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : endSim
    task automatic testFeature;
        cfg_host_model_i.wr(FEATURE_CFG_ADDR, 8'h1F);
        rdChk(FEATURE_CFG_ADDR, 8'h1F, "feature");
        chk("ssc", 8'h01, {7'h0, pllSscOff});
        chk("sts on", {4'h0, hubStatusIn}, {4'h0, sts});
        cfg_host_model_i.wr(FEATURE_CFG_ADDR, 8'h00);
        repeat (2) @(negedge clock);
        chk("sts off", 8'h00, {4'h0, sts});
        rdChk(8'h10, 8'h00, "unmapped");
        $display("feature test done");
    endtask : testFeature
    task automatic testDelay;
        cfg_host_model_i.wr(FEATURE_CFG_ADDR, 8'h02);
        @(negedge clock) powerRemoveReq = 1'b1;
        @(negedge clock) powerRemoveReq = 1'b0;
        n = 0;
        while (!portPowerEnableOut && n < 100) begin
            @(negedge clock);
            n++;
        end
        chk("hold", 8'h01, {7'h0, n >= STEP - 1 && n <= STEP + 2});
        $display("delay test done");
    endtask : testDelay
    task automatic testMode;
        setMode(CFG_MODE_I2C);
        chk("i2c entry", 8'h00, {7'h0, upstreamConnectAllow});
        cfg_host_model_i.wr(FEATURE_CFG_ADDR, 8'h01);
        cfg_host_model_i.wr(SERIAL_STS_ADDR, 8'h02);
        rdChk(SERIAL_STS_ADDR, 8'h01, "no reset in i2c");
        setMode(CFG_MODE_NONE);
        chk("i2c leave", 8'h01, {7'h0, upstreamConnectAllow});
        setMode(CFG_MODE_SMBUS);
        cfg_host_model_i.wr(SERIAL_STS_ADDR, 8'h00);
        chk("zero write", 8'h00, {7'h0, upstreamConnectAllow});
        cfg_host_model_i.wr(SERIAL_STS_ADDR, 8'h01);
        repeat (2) @(negedge clock);
        chk("flag clear", 8'h01, {7'h0, upstreamConnectAllow});
        cfg_host_model_i.wr(SERIAL_STS_ADDR, 8'h02);
        repeat (2) @(negedge clock);
        rdChk(SERIAL_STS_ADDR, 8'h01, "iface reset");
        rdChk(FEATURE_CFG_ADDR, 8'h00, "defaults");
        chk("flag set", 8'h00, {7'h0, upstreamConnectAllow});
        cfg_host_model_i.wr(FEATURE_CFG_ADDR, 8'h01);
        rdChk(FEATURE_CFG_ADDR, 8'h01, "rewrite");
        $display("mode test done");
    endtask : testMode
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        badCount++;
        endSim;
    end
    initial begin
        srst = 1'b1;
        cfgMode = CFG_MODE_NONE;
        powerRemoveReq = 1'b0;
        portPowerWanted = 1'b1;
        hubStatusIn = 4'h5;
        repeat (8) @(negedge clock);
        srst = 1'b0;
        testFeature;
        testDelay;
        testMode;
        endSim;
    end
endmodule : hub_feature_and_smbus_cfg_regs_bench
